// ===== hdl/logic_unit_pkg.sv
`timescale 1ns/1ns
package logic_unit_pkg;

  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    BITWISE_AND_OP = 4'h0,
    BITWISE_OR_OP = 4'h1,
    BITWISE_XOR_OP = 4'h2,
    WORKING_REGISTER_CLEAR_OP = 4'h3,
    WORKING_REGISTER_INVERT_OP = 4'h4,
    ROTATE_LEFT_PLAIN = 4'h5,
    ROTATE_LEFT_CARRY = 4'h6,
    ROTATE_RIGHT_PLAIN = 4'h7,
    ROTATE_RIGHT_CARRY = 4'h8
  } op_t;

  // ----------------------------------------
  // Operand forms
  // ----------------------------------------
  typedef enum logic [4:0] {
    FORM_ACC_BANK = 5'h00,
    FORM_ACC_SDIR = 5'h01,
    FORM_ACC_IND = 5'h02,
    FORM_ACC_IMM = 5'h03,
    FORM_SDIR_ACC = 5'h04,
    FORM_SDIR_IMM = 5'h05,
    FORM_BYTE_BYTE = 5'h06,
    FORM_WORD_WORD = 5'h07,
    FORM_BYTE_IMM = 5'h08,
    FORM_WORD_IMM = 5'h09,
    FORM_BYTE_SDIR = 5'h0A,
    FORM_WORD_SDIR = 5'h0B,
    FORM_BYTE_LDIR = 5'h0C,
    FORM_WORD_LDIR = 5'h0D,
    FORM_BYTE_AT_WORD = 5'h0E,
    FORM_BYTE_AT_DWORD = 5'h0F,
    FORM_ACC_ONLY = 5'h10
  } form_t;

  // Where a direct or memory operand lives
  typedef enum logic [1:0] {
    SPACE_RAM = 2'h0,
    SPACE_PORT = 2'h1,
    SPACE_SFR = 2'h2,
    SPACE_EXT = 2'h3
  } space_t;

  // ----------------------------------------
  // Extra state counts and reset values
  // ----------------------------------------
  localparam logic [5:0] PORT_RD_EXTRA = 6'h01;
  localparam logic [5:0] SFR_RD_EXTRA = 6'h02;
  localparam logic [5:0] PORT_WR_EXTRA = 6'h02;
  localparam logic [5:0] SFR_WR_EXTRA = 6'h03;
  localparam logic [5:0] EXT_FIXED_EXTRA = 6'h02;
  localparam logic [5:0] STATES_RESET = 6'h00;
  localparam logic [2:0] BYTES_RESET = 3'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Packed cost: {bytes bin, bytes src, states bin, states src}
  function automatic logic [11:0] form_cost(input form_t f);
    case (f)
      FORM_ACC_BANK: return {3'h1, 3'h2, 3'h1, 3'h2};
      FORM_ACC_SDIR: return {3'h2, 3'h2, 3'h1, 3'h1};
      FORM_ACC_IND: return {3'h1, 3'h2, 3'h2, 3'h3};
      FORM_ACC_IMM: return {3'h2, 3'h2, 3'h1, 3'h1};
      FORM_SDIR_ACC: return {3'h2, 3'h2, 3'h2, 3'h2};
      FORM_SDIR_IMM: return {3'h3, 3'h3, 3'h3, 3'h3};
      FORM_BYTE_BYTE: return {3'h3, 3'h2, 3'h2, 3'h1};
      FORM_WORD_WORD: return {3'h3, 3'h2, 3'h3, 3'h2};
      FORM_BYTE_IMM: return {3'h4, 3'h3, 3'h3, 3'h2};
      FORM_WORD_IMM: return {3'h5, 3'h4, 3'h4, 3'h3};
      FORM_BYTE_SDIR: return {3'h4, 3'h3, 3'h3, 3'h2};
      FORM_WORD_SDIR: return {3'h4, 3'h3, 3'h4, 3'h3};
      FORM_BYTE_LDIR: return {3'h5, 3'h4, 3'h3, 3'h2};
      FORM_WORD_LDIR: return {3'h5, 3'h4, 3'h4, 3'h3};
      FORM_BYTE_AT_WORD: return {3'h4, 3'h3, 3'h3, 3'h2};
      FORM_BYTE_AT_DWORD: return {3'h4, 3'h3, 3'h4, 3'h3};
      default: return {3'h1, 3'h1, 3'h1, 3'h1};
    endcase
  endfunction : form_cost

  function automatic logic is_word(input form_t f);
    return (f == FORM_WORD_WORD) || (f == FORM_WORD_IMM) ||
           (f == FORM_WORD_SDIR) || (f == FORM_WORD_LDIR);
  endfunction : is_word

endpackage : logic_unit_pkg

// ----------------------------------------
// Result calculation
// ----------------------------------------
module logic_result_calc
  import logic_unit_pkg::*;
(
  // Operation
  input wire op_t op,
  input wire logic word,
  // Operands
  input wire logic [15:0] dst,
  input wire logic [15:0] src,
  input wire logic carry_in,
  // Result
  output wire logic [15:0] res,
  output wire logic carry_out
);
  wire logic [15:0] mask;
  wire logic [15:0] and_v;
  wire logic [15:0] or_v;
  wire logic [15:0] xor_v;
  wire logic [7:0] acc;
  wire logic [15:0] raw;

  assign mask = word ? 16'hFFFF : 16'h00FF;
  assign and_v = dst & src;
  assign or_v = dst | src;
  assign xor_v = dst ^ src;
  assign acc = dst[7:0];
  assign raw =
    (op == BITWISE_AND_OP) ? and_v :
    (op == BITWISE_OR_OP) ? or_v :
    (op == BITWISE_XOR_OP) ? xor_v :
    (op == WORKING_REGISTER_CLEAR_OP) ? 16'h0000 :
    (op == WORKING_REGISTER_INVERT_OP) ? {8'h00, ~acc} :
    (op == ROTATE_LEFT_PLAIN) ? {8'h00, acc[6:0], acc[7]} :
    (op == ROTATE_LEFT_CARRY) ? {8'h00, acc[6:0], carry_in} :
    (op == ROTATE_RIGHT_PLAIN) ? {8'h00, acc[0], acc[7:1]} :
    (op == ROTATE_RIGHT_CARRY) ? {8'h00, carry_in, acc[7:1]} :
    dst;
  assign res = raw & mask;
  assign carry_out =
    (op == ROTATE_LEFT_CARRY) ? acc[7] :
    (op == ROTATE_RIGHT_CARRY) ? acc[0] :
    carry_in;
endmodule : logic_result_calc

// ===== hdl/logical_instruction_unit.sv
`timescale 1ns/1ns
module logical_instruction_unit
  import logic_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Instruction request
  input wire logic start,
  input wire op_t op,
  input wire form_t form,
  input wire logic source_mode,
  input wire space_t space,
  input wire logic [3:0] wait_states,
  // Operands
  input wire logic [15:0] dst_operand,
  input wire logic [15:0] src_operand,
  input wire logic carry_flag,
  // Status and result
  output logic busy_q,
  output logic done_q,
  output logic [15:0] result_q,
  output logic carry_q,
  output logic [2:0] bytes_q,
  output logic [5:0] states_q
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } seq_t;

  seq_t state_q;
  seq_t state_d;
  op_t op_q;
  logic word_q;
  logic [15:0] dst_q;
  logic [15:0] src_q;
  logic cin_q;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;

  // ----------------------------------------
  // Cost decode
  // ----------------------------------------
  wire logic [11:0] cost;
  wire logic [2:0] base_bytes;
  wire logic [5:0] base_states;
  wire logic rd_direct;
  wire logic wr_direct;
  wire logic ext_byte;
  wire logic ext_word;
  wire logic [5:0] n_plus2;
  wire logic [5:0] rd_extra;
  wire logic [5:0] wr_extra;
  wire logic [5:0] ext_extra;
  wire logic [5:0] total_states;
  wire logic accept;
  wire logic last;
  wire logic [15:0] calc_res;
  wire logic calc_carry;

  assign cost = form_cost(form);
  assign base_bytes = source_mode ? cost[8:6] : cost[11:9];
  assign base_states = source_mode ?
    {3'h0, cost[2:0]} : {3'h0, cost[5:3]};

  assign rd_direct = (form == FORM_ACC_SDIR) ||
                     (form == FORM_BYTE_SDIR);
  assign wr_direct = (form == FORM_SDIR_ACC) ||
                     (form == FORM_SDIR_IMM);
  // A port or SFR cannot sit in external space, so the sets are apart
  assign ext_byte = (space == SPACE_EXT) &&
                    ((form == FORM_BYTE_LDIR) ||
                     (form == FORM_BYTE_AT_WORD) ||
                     (form == FORM_BYTE_AT_DWORD));
  assign ext_word = (space == SPACE_EXT) && (form == FORM_WORD_LDIR);

  assign n_plus2 = {2'h0, wait_states} + EXT_FIXED_EXTRA;
  assign rd_extra = !rd_direct ? 6'h00 :
    (space == SPACE_PORT) ? PORT_RD_EXTRA :
    (space == SPACE_SFR) ? SFR_RD_EXTRA : 6'h00;
  assign wr_extra = !wr_direct ? 6'h00 :
    (space == SPACE_PORT) ? PORT_WR_EXTRA :
    (space == SPACE_SFR) ? SFR_WR_EXTRA : 6'h00;
  assign ext_extra = ext_word ? {n_plus2[4:0], 1'b0} :
    ext_byte ? n_plus2 : 6'h00;
  assign total_states = base_states + rd_extra + wr_extra + ext_extra;

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  // Requests arriving while busy are dropped, not queued
  assign accept = start && (state_q == ST_IDLE);
  assign last = (state_q == ST_RUN) && (cnt_q == 6'h00);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_RUN;
          cnt_d = total_states - 6'h01;
        end
      end
      ST_RUN:
      begin
        if (last)
          state_d = ST_IDLE;
        else
          cnt_d = cnt_q - 6'h01;
      end
      default:
      begin
        state_d = ST_IDLE;
        cnt_d = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_q <= BITWISE_AND_OP;
      word_q <= 1'b0;
      dst_q <= RESULT_RESET;
      src_q <= RESULT_RESET;
      cin_q <= 1'b0;
    end
    else if (accept)
    begin
      op_q <= op;
      word_q <= is_word(form);
      dst_q <= dst_operand;
      src_q <= src_operand;
      cin_q <= carry_flag;
    end
  end

  logic_result_calc logic_result_calc_inst (
    .op(op_q),
    .word(word_q),
    .dst(dst_q),
    .src(src_q),
    .carry_in(cin_q),
    .res(calc_res),
    .carry_out(calc_carry)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      bytes_q <= BYTES_RESET;
      states_q <= STATES_RESET;
    end
    else
    begin
      busy_q <= accept || (busy_q && !last);
      done_q <= last;
      if (accept)
      begin
        bytes_q <= base_bytes;
        states_q <= total_states;
      end
    end
  end

  // Result moves only at the end so it never shows half an instruction
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_q <= RESULT_RESET;
      carry_q <= 1'b0;
    end
    else if (last)
    begin
      result_q <= calc_res;
      carry_q <= calc_carry;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [5:0] run_len_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      run_len_q <= 6'h00;
    else if (accept)
      run_len_q <= 6'h01;
    else if (busy_q && !last)
      run_len_q <= run_len_q + 6'h01;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  run_length_a: assert property (
    done_q |-> run_len_q == states_q)
    else $error("busy length differs from state count");

  byte_byte_a: assert property (
    accept && form == FORM_BYTE_BYTE |=>
    states_q == ($past(source_mode) ? 6'h01 : 6'h02) &&
    bytes_q == ($past(source_mode) ? 3'h2 : 3'h3))
    else $error("byte to byte cost wrong");

  word_imm_a: assert property (
    accept && form == FORM_WORD_IMM |=>
    states_q == ($past(source_mode) ? 6'h03 : 6'h04) &&
    bytes_q == ($past(source_mode) ? 3'h4 : 3'h5))
    else $error("word immediate cost wrong");

  port_read_a: assert property (
    accept && form == FORM_ACC_SDIR |=>
    states_q == ($past(space) == SPACE_PORT ? 6'h02 :
                 $past(space) == SPACE_SFR ? 6'h03 : 6'h01))
    else $error("direct read extra states wrong");

  direct_write_a: assert property (
    accept && form == FORM_SDIR_ACC |=>
    states_q == ($past(space) == SPACE_PORT ? 6'h04 :
                 $past(space) == SPACE_SFR ? 6'h05 : 6'h02))
    else $error("direct write extra states wrong");

  ext_byte_a: assert property (
    accept && form == FORM_BYTE_AT_DWORD && space == SPACE_EXT
    |=> states_q == ($past(source_mode) ? 6'h03 : 6'h04) +
                    {2'h0, $past(wait_states)} + 6'h02)
    else $error("external byte wait states wrong");

  ext_word_a: assert property (
    accept && form == FORM_WORD_LDIR && space == SPACE_EXT
    |=> states_q == ($past(source_mode) ? 6'h03 : 6'h04) +
        {1'b0, $past(wait_states), 1'b0} + 6'h04)
    else $error("external word wait states wrong");

  xor_result_a: assert property (
    done_q && op_q == BITWISE_XOR_OP |->
    result_q[7:0] == (dst_q[7:0] ^ src_q[7:0]))
    else $error("xor result wrong");

  rotate_left_a: assert property (
    done_q && op_q == ROTATE_LEFT_CARRY |->
    result_q[7:0] == {dst_q[6:0], cin_q} && carry_q == dst_q[7])
    else $error("left carry rotate wrong");

  rotate_right_a: assert property (
    done_q && op_q == ROTATE_RIGHT_PLAIN |->
    result_q[7:0] == {dst_q[0], dst_q[7:1]} && carry_q == cin_q)
    else $error("right rotate wrong");

  clear_state_a: assert property (
    accept && op == WORKING_REGISTER_CLEAR_OP &&
    form == FORM_ACC_ONLY |=> busy_q ##1 done_q && result_q == 16'h0000)
    else $error("clear not one state");

  ext_word_c: cover property (
    accept && form == FORM_WORD_LDIR && space == SPACE_EXT);
  rrc_done_c: cover property (done_q && op_q == ROTATE_RIGHT_CARRY);
  back_to_back_c: cover property (done_q && accept);

endmodule : logical_instruction_unit

// ===== tb/logical_instruction_unit_tb_top.sv
`timescale 1ns/1ns
module logical_instruction_unit_tb_top
  import logic_unit_pkg::*;
;

  // ----------------------------------------
  // Stimulus and observed outputs
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  op_t op = BITWISE_AND_OP;
  form_t form = FORM_ACC_ONLY;
  logic source_mode = 1'b0;
  space_t space = SPACE_RAM;
  logic [3:0] wait_states = 4'h0;
  logic [15:0] dst_operand = 16'h0000;
  logic [15:0] src_operand = 16'h0000;
  logic carry_flag = 1'b0;
  logic busy_q;
  logic done_q;
  logic carry_q;
  logic [15:0] result_q;
  logic [2:0] bytes_q;
  logic [5:0] states_q;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;

  logical_instruction_unit logical_instruction_unit_inst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(start),
    .op(op),
    .form(form),
    .source_mode(source_mode),
    .space(space),
    .wait_states(wait_states),
    .dst_operand(dst_operand),
    .src_operand(src_operand),
    .carry_flag(carry_flag),
    .busy_q(busy_q),
    .done_q(done_q),
    .result_q(result_q),
    .carry_q(carry_q),
    .bytes_q(bytes_q),
    .states_q(states_q)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Bounded wait, so a missing done pulse cannot hang the run
  task automatic wait_done(output int k, output int b);
    k = 0;
    b = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      k++;
      if (busy_q === 1'b1)
        b++;
    end
    while (done_q !== 1'b1 && k < 80);
  endtask : wait_done

  task automatic run(input op_t o, input form_t f, input logic m,
    input space_t sp, input logic [3:0] n, input logic [15:0] d,
    input logic [15:0] s, input logic c, input logic [15:0] er,
    input logic ec, input logic [2:0] eb, input logic [5:0] es);
    int k;
    int b;
    @(posedge clk_sys);
    start <= 1'b1;
    op <= o;
    form <= f;
    source_mode <= m;
    space <= sp;
    wait_states <= n;
    dst_operand <= d;
    src_operand <= s;
    carry_flag <= c;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    check(16'(bytes_q), 16'(eb));
    check(16'(states_q), 16'(es));
    check(16'(busy_q), 16'h0001);
    wait_done(k, b);
    check(16'(k), 16'(es));
    check(16'(b), 16'(es - 6'h01));
    check(result_q, er);
    check(16'(carry_q), 16'(ec));
    @(posedge clk_sys);
    #1;
    check(16'(done_q), 16'h0000);
  endtask : run

  // Junk above a byte destination must not reach the upper result byte
  task automatic one_form(input form_t f, input logic w,
    input logic [2:0] bb, input logic [5:0] bs,
    input logic [2:0] sb, input logic [5:0] ss);
    logic [15:0] d;
    logic [15:0] s;
    logic [15:0] e;
    d = w ? 16'hA5C3 : 16'h5AC3;
    s = w ? 16'h3C96 : 16'h0096;
    e = d ^ s;
    if (!w)
      e[15:8] = 8'h00;
    run(BITWISE_XOR_OP, f, 1'b0, SPACE_RAM, 4'h0, d, s, 1'b1, e,
      1'b1, bb, bs);
    run(BITWISE_XOR_OP, f, 1'b1, SPACE_RAM, 4'h0, d, s, 1'b1, e,
      1'b1, sb, ss);
  endtask : one_form

  task automatic acc(input op_t o, input logic m, input logic [15:0] d,
    input logic c, input logic [15:0] er, input logic ec);
    run(o, FORM_ACC_ONLY, m, SPACE_RAM, 4'h0, d, 16'h0000, c, er, ec,
      3'h1, 6'h01);
  endtask : acc

  task automatic ext(input form_t f, input logic m, input space_t sp,
    input logic [3:0] n, input logic w, input logic [2:0] eb,
    input logic [5:0] es);
    run(BITWISE_AND_OP, f, m, sp, n, w ? 16'hF0F0 : 16'h00F0,
      w ? 16'h3C3C : 16'h003C, 1'b0, w ? 16'h3030 : 16'h0030, 1'b0, eb, es);
  endtask : ext

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_logic;
    run(BITWISE_AND_OP, FORM_WORD_IMM, 1'b0, SPACE_RAM, 4'h0, 16'hF0F0,
      16'h3CC3, 1'b0, 16'h30C0, 1'b0, 3'h5, 6'h04);
    run(BITWISE_OR_OP, FORM_ACC_IMM, 1'b1, SPACE_RAM, 4'h0, 16'h0050,
      16'h000A, 1'b0, 16'h005A, 1'b0, 3'h2, 6'h01);
  endtask : t_logic

  task automatic t_forms;
    one_form(FORM_ACC_BANK, 1'b0, 3'h1, 6'h01, 3'h2, 6'h02);
    one_form(FORM_ACC_SDIR, 1'b0, 3'h2, 6'h01, 3'h2, 6'h01);
    one_form(FORM_ACC_IND, 1'b0, 3'h1, 6'h02, 3'h2, 6'h03);
    one_form(FORM_SDIR_ACC, 1'b0, 3'h2, 6'h02, 3'h2, 6'h02);
    one_form(FORM_SDIR_IMM, 1'b0, 3'h3, 6'h03, 3'h3, 6'h03);
    one_form(FORM_BYTE_BYTE, 1'b0, 3'h3, 6'h02, 3'h2, 6'h01);
    one_form(FORM_WORD_WORD, 1'b1, 3'h3, 6'h03, 3'h2, 6'h02);
    one_form(FORM_BYTE_IMM, 1'b0, 3'h4, 6'h03, 3'h3, 6'h02);
    one_form(FORM_WORD_IMM, 1'b1, 3'h5, 6'h04, 3'h4, 6'h03);
    one_form(FORM_BYTE_SDIR, 1'b0, 3'h4, 6'h03, 3'h3, 6'h02);
    one_form(FORM_WORD_SDIR, 1'b1, 3'h4, 6'h04, 3'h3, 6'h03);
    one_form(FORM_BYTE_LDIR, 1'b0, 3'h5, 6'h03, 3'h4, 6'h02);
    one_form(FORM_WORD_LDIR, 1'b1, 3'h5, 6'h04, 3'h4, 6'h03);
    one_form(FORM_BYTE_AT_WORD, 1'b0, 3'h4, 6'h03, 3'h3, 6'h02);
    one_form(FORM_BYTE_AT_DWORD, 1'b0, 3'h4, 6'h04, 3'h3, 6'h03);
  endtask : t_forms

  task automatic t_acc;
    acc(WORKING_REGISTER_CLEAR_OP, 1'b1, 16'h00B4, 1'b1, 16'h0000, 1'b1);
    acc(WORKING_REGISTER_INVERT_OP, 1'b0, 16'h00B4, 1'b0, 16'h004B, 1'b0);
    acc(ROTATE_LEFT_PLAIN, 1'b0, 16'h00B4, 1'b0, 16'h0069, 1'b0);
    acc(ROTATE_LEFT_CARRY, 1'b1, 16'h00B4, 1'b0, 16'h0068, 1'b1);
    acc(ROTATE_LEFT_CARRY, 1'b0, 16'h0034, 1'b1, 16'h0069, 1'b0);
    acc(ROTATE_RIGHT_PLAIN, 1'b1, 16'h00B4, 1'b1, 16'h005A, 1'b1);
    acc(ROTATE_RIGHT_CARRY, 1'b0, 16'h00B4, 1'b1, 16'h00DA, 1'b0);
    acc(ROTATE_RIGHT_CARRY, 1'b1, 16'h0035, 1'b0, 16'h001A, 1'b1);
  endtask : t_acc

  task automatic t_extra;
    ext(FORM_ACC_SDIR, 1'b0, SPACE_PORT, 4'h0, 1'b0, 3'h2, 6'h02);
    ext(FORM_ACC_SDIR, 1'b1, SPACE_SFR, 4'h0, 1'b0, 3'h2, 6'h03);
    ext(FORM_BYTE_SDIR, 1'b1, SPACE_SFR, 4'h0, 1'b0, 3'h3, 6'h04);
    ext(FORM_SDIR_ACC, 1'b0, SPACE_PORT, 4'h0, 1'b0, 3'h2, 6'h04);
    ext(FORM_SDIR_ACC, 1'b1, SPACE_SFR, 4'h0, 1'b0, 3'h2, 6'h05);
    ext(FORM_SDIR_IMM, 1'b0, SPACE_SFR, 4'h0, 1'b0, 3'h3, 6'h06);
    ext(FORM_BYTE_LDIR, 1'b0, SPACE_EXT, 4'h0, 1'b0, 3'h5, 6'h05);
    ext(FORM_BYTE_AT_WORD, 1'b1, SPACE_EXT, 4'hF, 1'b0, 3'h3, 6'h13);
    ext(FORM_BYTE_AT_DWORD, 1'b0, SPACE_EXT, 4'h3, 1'b0, 3'h4, 6'h09);
    ext(FORM_WORD_LDIR, 1'b1, SPACE_EXT, 4'h0, 1'b1, 3'h4, 6'h07);
    ext(FORM_WORD_LDIR, 1'b0, SPACE_EXT, 4'hF, 1'b1, 3'h5, 6'h26);
  endtask : t_extra

  // Start held high: ignored while busy, taken in the done cycle
  task automatic t_busy;
    int k;
    int b;
    @(posedge clk_sys);
    start <= 1'b1;
    op <= BITWISE_AND_OP;
    form <= FORM_WORD_IMM;
    source_mode <= 1'b0;
    dst_operand <= 16'hFFFF;
    src_operand <= 16'h1234;
    @(posedge clk_sys);
    op <= BITWISE_XOR_OP;
    form <= FORM_BYTE_BYTE;
    source_mode <= 1'b1;
    dst_operand <= 16'h00F0;
    src_operand <= 16'h00FF;
    wait_done(k, b);
    check(16'(k), 16'h0004);
    check(result_q, 16'h1234);
    check(16'(states_q), 16'h0004);
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    check(16'(bytes_q), 16'h0002);
    check(16'(states_q), 16'h0001);
    wait_done(k, b);
    check(16'(k), 16'h0001);
    check(result_q, 16'h000F);
  endtask : t_busy

  // Reset in mid-instruction clears everything, then work resumes
  task automatic t_reset;
    @(posedge clk_sys);
    start <= 1'b1;
    op <= BITWISE_OR_OP;
    form <= FORM_WORD_LDIR;
    source_mode <= 1'b0;
    space <= SPACE_EXT;
    wait_states <= 4'h2;
    dst_operand <= 16'h1200;
    src_operand <= 16'h0034;
    carry_flag <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    check(16'(states_q), 16'h000C);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    #1;
    check(16'(busy_q), 16'h0000);
    check(16'(states_q), 16'h0000);
    check(16'(bytes_q), 16'h0000);
    check(result_q, 16'h0000);
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(16'(busy_q), 16'h0000);
    check(16'(done_q), 16'h0000);
    check(16'(carry_q), 16'h0000);
    run(BITWISE_OR_OP, FORM_WORD_LDIR, 1'b0, SPACE_EXT, 4'h2, 16'h1200,
      16'h0034, 1'b1, 16'h1234, 1'b1, 3'h5, 6'h0C);
  endtask : t_reset

  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fails++;
      stop_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_logic();
    t_forms();
    t_acc();
    t_extra();
    t_busy();
    t_reset();
    stop_test();
  end

endmodule : logical_instruction_unit_tb_top
